// >>> core/oscc_pkg.sv
// Purpose: Shared constants for the one-shot and pulse-width capture timer
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Offsets are a local choice, one word apart
package oscc_pkg;
    // Register byte offsets
    localparam logic [7:0] OSCC_OFF_MODE   = 8'h00;
    localparam logic [7:0] OSCC_OFF_CCCFG  = 8'h04;
    localparam logic [7:0] OSCC_OFF_OUTCTL = 8'h08;
    localparam logic [7:0] OSCC_OFF_COUNT  = 8'h0c;
    localparam logic [7:0] OSCC_OFF_CCF    = 8'h10;
    localparam logic [7:0] OSCC_OFF_CCS    = 8'h14;
    localparam logic [7:0] OSCC_OFF_EDGE   = 8'h18;
    localparam logic [7:0] OSCC_OFF_STAT   = 8'h1c;
    localparam logic [7:0] OSCC_OFF_PRESC  = 8'h20;
    // Mode control fields
    localparam int OSCC_MODE_OVF_BIT = 0;
    localparam int OSCC_MODE_LO_BIT  = 2;
    localparam logic [1:0] OSCC_MODE_STOP = 2'h0;
    localparam logic [1:0] OSCC_MODE_FREE = 2'h1;
    localparam logic [1:0] OSCC_MODE_CLRI = 2'h2;
    // Output control fields
    localparam int OSCC_OC_PIN_EN_BIT = 0;
    localparam int OSCC_OC_TOG1_BIT   = 1;
    localparam int OSCC_OC_TOG2_BIT   = 4;
    localparam int OSCC_OC_OS_EN_BIT  = 5;
    localparam int OSCC_OC_TRIG_BIT   = 6;
    // Capture config: bit0 first reg is capture, bit1 first reg trigger
    // is opposite edge of input one (else input two), bit2 second is capture
    localparam int OSCC_CC_FIRST_CAP_BIT  = 0;
    localparam int OSCC_CC_FIRST_OPP_BIT  = 1;
    localparam int OSCC_CC_SECOND_CAP_BIT = 2;
    // Edge select codes: 0 falling, 1 rising, 2 none, 3 both
    localparam logic [1:0] OSCC_EDGE_FALL = 2'h0;
    localparam logic [1:0] OSCC_EDGE_RISE = 2'h1;
    localparam logic [1:0] OSCC_EDGE_BOTH = 2'h3;
    // Reset values
    localparam logic [7:0]  OSCC_RST_REG8  = 8'h00;
    localparam logic [15:0] OSCC_RST_REG16 = 16'h0000;
    localparam logic [7:0]  OSCC_RST_PRESC = 8'h00;
endpackage : oscc_pkg

// >>> core/oscc_edge_if.sv
// Purpose: Carries synchronised capture input edge events
// Assumes: Single pclk domain
// Notes:   Pulses last one pclk cycle
`timescale 1ns/1ps
interface oscc_edge_if;
    logic in1_valid;   // Valid edge on input one
    logic in1_opp;     // Opposite edge on input one
    logic in2_valid;   // Valid edge on input two
    modport src (output in1_valid, output in1_opp, output in2_valid);
    modport dst (input in1_valid, input in1_opp, input in2_valid);
endinterface : oscc_edge_if

// >>> core/oscc_edge_det.sv
// Purpose: Synchronise two capture pins and detect selected edges
// Assumes: Pins are asynchronous to pclk
// Notes:   First sync flop feeds only the second
`timescale 1ns/1ps
module oscc_edge_det
    import oscc_pkg::*;
(
    input  wire logic       pclk,      // Bus clock
    input  wire logic       presetn,   // Async reset, low
    input  wire logic       pin1,      // Capture input one
    input  wire logic       pin2,      // Capture input two
    input  wire logic [1:0] sel1,      // Edge select input one
    input  wire logic [1:0] sel2,      // Edge select input two
    oscc_edge_if.src        ev         // Edge events
);
    logic [1:0] s1_reg, s2_reg;
    logic [1:0] s1_q, s2_q;
    logic       r1, f1, r2, f2;

    // Two-flop synchronisers plus two further stages, the last one as history
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_reg <= 2'h0;
            s2_reg <= 2'h0;
            s1_q   <= 2'h0;
            s2_q   <= 2'h0;
        end
        else
        begin
            s1_reg <= {s1_reg[0], pin1};
            s2_reg <= {s2_reg[0], pin2};
            s1_q   <= {s1_q[0], s1_reg[1]};
            s2_q   <= {s2_q[0], s2_reg[1]};
        end
    end

    // Edge decode on synchronised samples only
    assign r1 = s1_q[0] & ~s1_q[1];
    assign f1 = ~s1_q[0] & s1_q[1];
    assign r2 = s2_q[0] & ~s2_q[1];
    assign f2 = ~s2_q[0] & s2_q[1];

    function automatic logic pick(input logic [1:0] s, input logic r,
                                  input logic f);
        pick = (s == OSCC_EDGE_RISE) ? r :
               (s == OSCC_EDGE_FALL) ? f :
               (s == OSCC_EDGE_BOTH) ? (r | f) : 1'b0;
    endfunction : pick

    assign ev.in1_valid = pick(sel1, r1, f1);
    // Opposite phase: with both edges selected there is no opposite edge
    assign ev.in1_opp   = (sel1 == OSCC_EDGE_RISE) ? f1 :
                          (sel1 == OSCC_EDGE_FALL) ? r1 : 1'b0;
    assign ev.in2_valid = pick(sel2, r2, f2);
endmodule : oscc_edge_det

// >>> core/oscc_timer.sv
// Purpose: One-shot pulse output and pulse-width capture timer channel
// Assumes: APB slave on pclk 20 MHz; count clock is a prescaler enable
// Notes:   Capture pins are synchronised before use
`timescale 1ns/1ps
module oscc_timer
    import oscc_pkg::*;
(
    input  wire logic        pclk,       // Bus and core clock
    input  wire logic        presetn,    // Async reset, low
    input  wire logic        psel,       // APB select
    input  wire logic        penable,    // APB enable
    input  wire logic        pwrite,     // APB direction
    input  wire logic [7:0]  paddr,      // APB byte address
    input  wire logic [31:0] pwdata,     // APB write data
    output logic      [31:0] prdata,     // APB read data
    output logic             pready,     // APB ready
    output logic             pslverr,    // APB error, unmapped
    input  wire logic        capture_input_first,  // Capture pin one
    input  wire logic        capture_input_second, // Capture pin two
    output logic             timer_output_pin,     // Timer output
    output logic             first_match_irq,      // Irq one pulse
    output logic             second_match_irq      // Irq two pulse
);
    import oscc_pkg::*;

    logic [7:0]  mode_control_reg;
    logic [7:0]  capture_compare_config_reg;
    logic [7:0]  output_control_reg;
    logic [7:0]  edge_sel_reg;
    logic [7:0]  prescaler_select_reg;
    logic [15:0] up_counter;
    logic [15:0] capture_compare_first;
    logic [15:0] capture_compare_second;
    logic [7:0]  presc_cnt_reg;
    logic        tout_reg;
    logic        active_reg;
    logic        armed_reg;
    logic [31:0] rdata_next;
    logic        cnt_tick;
    logic        run;
    logic        wr_en;
    logic        rd_en;
    logic        soft_trig;
    logic        os_on;
    logic        trig;
    logic        m1;
    logic        m2;
    logic        cap_first;
    logic        cap_second;
    logic        cap_first_irq;
    logic        ovf_evt;
    logic        mapped;
    logic [1:0]  mode;

    oscc_edge_if ev ();

    oscc_edge_det u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .pin1    (capture_input_first),
        .pin2    (capture_input_second),
        .sel1    (edge_sel_reg[1:0]),
        .sel2    (edge_sel_reg[3:2]),
        .ev      (ev)
    );

    // Decode helpers
    assign mode   = mode_control_reg[OSCC_MODE_LO_BIT +: 2];
    assign run    = (mode != OSCC_MODE_STOP);
    assign wr_en  = psel & penable & pwrite;
    assign rd_en  = psel & ~penable & ~pwrite;
    assign mapped = (paddr <= OSCC_OFF_PRESC) && (paddr[1:0] == 2'h0);
    assign soft_trig = wr_en && (paddr == OSCC_OFF_OUTCTL)
                       && pwdata[OSCC_OC_TRIG_BIT];
    // One-shot allowed only in free or input-clear modes
    assign os_on  = output_control_reg[OSCC_OC_OS_EN_BIT]
                    && (mode == OSCC_MODE_FREE || mode == OSCC_MODE_CLRI);
    assign trig   = os_on && (soft_trig || ev.in1_valid);
    // Compare matches sampled on count clock
    assign m1 = run && cnt_tick
                && !capture_compare_config_reg[OSCC_CC_FIRST_CAP_BIT]
                && (up_counter == capture_compare_first);
    assign m2 = run && cnt_tick
                && !capture_compare_config_reg[OSCC_CC_SECOND_CAP_BIT]
                && (up_counter == capture_compare_second);
    // Capture triggers; second always follows input one
    assign cap_second = run
        && capture_compare_config_reg[OSCC_CC_SECOND_CAP_BIT]
        && ev.in1_valid;
    assign cap_first = run
        && capture_compare_config_reg[OSCC_CC_FIRST_CAP_BIT]
        && (capture_compare_config_reg[OSCC_CC_FIRST_OPP_BIT]
            ? ev.in1_opp : ev.in2_valid);
    // Opposite-edge capture is silent
    assign cap_first_irq = cap_first
        && !capture_compare_config_reg[OSCC_CC_FIRST_OPP_BIT];
    assign ovf_evt = run && cnt_tick && (up_counter == 16'hffff);

    // Count clock enable from prescaler divider
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            presc_cnt_reg <= OSCC_RST_REG8;
        else if (!run || presc_cnt_reg >= prescaler_select_reg)
            presc_cnt_reg <= OSCC_RST_REG8;
        else
            presc_cnt_reg <= presc_cnt_reg + 8'h01;
    end
    assign cnt_tick = run && (presc_cnt_reg >= prescaler_select_reg);

    // Up counter; clears on trigger or valid edge in clear mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            up_counter <= OSCC_RST_REG16;
        else if (!run)
            up_counter <= OSCC_RST_REG16;
        else if (trig)
            up_counter <= OSCC_RST_REG16;
        else if (mode == OSCC_MODE_CLRI && ev.in1_valid)
            up_counter <= OSCC_RST_REG16;
        else if (cnt_tick)
            up_counter <= up_counter + 16'h0001;
    end

    // Mode register with sticky overflow; set beats clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_control_reg <= OSCC_RST_REG8;
        else
        begin
            if (wr_en && paddr == OSCC_OFF_MODE)
                mode_control_reg <= pwdata[7:0];
            if (ovf_evt)
                mode_control_reg[OSCC_MODE_OVF_BIT] <= 1'b1;
        end
    end

    // Plain configuration registers; trigger bit reads back zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            capture_compare_config_reg <= OSCC_RST_REG8;
            output_control_reg         <= OSCC_RST_REG8;
            edge_sel_reg               <= OSCC_RST_REG8;
            prescaler_select_reg       <= OSCC_RST_PRESC;
        end
        else if (wr_en)
        begin
            if (paddr == OSCC_OFF_CCCFG)
                capture_compare_config_reg <= pwdata[7:0];
            if (paddr == OSCC_OFF_OUTCTL)
                output_control_reg <= pwdata[7:0] & 8'hbf;
            if (paddr == OSCC_OFF_EDGE)
                edge_sel_reg <= pwdata[7:0];
            if (paddr == OSCC_OFF_PRESC)
                prescaler_select_reg <= pwdata[7:0];
        end
    end

    // Capture/compare registers; hardware capture wins over a write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            capture_compare_first  <= OSCC_RST_REG16;
            capture_compare_second <= OSCC_RST_REG16;
        end
        else
        begin
            if (cap_first)
                capture_compare_first <= up_counter;
            else if (wr_en && paddr == OSCC_OFF_CCF)
                capture_compare_first <= pwdata[15:0];
            if (cap_second)
                capture_compare_second <= up_counter;
            else if (wr_en && paddr == OSCC_OFF_CCS)
                capture_compare_second <= pwdata[15:0];
        end
    end

    // Output pin: toggles on matches; in one-shot only once per trigger,
    // so a counter wrap cannot repeat the pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tout_reg   <= 1'b0;
            active_reg <= 1'b0;
            armed_reg  <= 1'b0;
        end
        else if (!run)
        begin
            active_reg <= 1'b0;
            armed_reg  <= 1'b0;
        end
        else
        begin
            if (m1 && output_control_reg[OSCC_OC_TOG1_BIT]
                && (!os_on || armed_reg))
                tout_reg <= ~tout_reg;
            else if (m2 && output_control_reg[OSCC_OC_TOG2_BIT]
                     && (!os_on || active_reg))
                tout_reg <= ~tout_reg;
            if (trig)
                armed_reg <= 1'b1;
            else if (m1)
                armed_reg <= 1'b0;
            if (m1 && os_on && armed_reg)
                active_reg <= 1'b1;
            else if (m2 && os_on)
                active_reg <= 1'b0;
        end
    end

    // Registered outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_output_pin <= 1'b0;
            first_match_irq  <= 1'b0;
            second_match_irq <= 1'b0;
        end
        else
        begin
            timer_output_pin <= tout_reg
                                & output_control_reg[OSCC_OC_PIN_EN_BIT];
            first_match_irq  <= m1 | cap_first_irq;
            second_match_irq <= m2 | cap_second;
        end
    end

    // Read mux; counter read is a pure observation
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        case (paddr)
            OSCC_OFF_MODE:   rdata_next[7:0]  = mode_control_reg;
            OSCC_OFF_CCCFG:  rdata_next[7:0]  = capture_compare_config_reg;
            OSCC_OFF_OUTCTL: rdata_next[7:0]  = output_control_reg;
            OSCC_OFF_COUNT:  rdata_next[15:0] = up_counter;
            OSCC_OFF_CCF:    rdata_next[15:0] = capture_compare_first;
            OSCC_OFF_CCS:    rdata_next[15:0] = capture_compare_second;
            OSCC_OFF_EDGE:   rdata_next[7:0]  = edge_sel_reg;
            OSCC_OFF_STAT:   rdata_next[1:0]  = {active_reg, tout_reg};
            OSCC_OFF_PRESC:  rdata_next[7:0]  = prescaler_select_reg;
            default:         rdata_next       = 32'h0000_0000;
        endcase
    end

    // APB response: zero wait states, data latched in setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            if (rd_en)
                prdata <= rdata_next;
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
        end
    end

    // Checks
    AST_OVF_SET: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_evt |=> mode_control_reg[OSCC_MODE_OVF_BIT])
        else $error("overflow flag not set");
    AST_MATCH1_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        m1 |=> first_match_irq)
        else $error("first match irq missing");
    AST_MATCH2_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        m2 |=> second_match_irq)
        else $error("second match irq missing");
    AST_TOGGLE1: assert property (@(posedge pclk) disable iff (!presetn)
        (m1 && run && output_control_reg[OSCC_OC_TOG1_BIT]
         && (!os_on || armed_reg))
        |=> tout_reg != $past(tout_reg))
        else $error("pin did not toggle on first match");
    AST_STOP_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        !run |=> up_counter == 16'h0000)
        else $error("counter not held at zero");
    AST_CAP2: assert property (@(posedge pclk) disable iff (!presetn)
        cap_second |=> capture_compare_second == $past(up_counter))
        else $error("second capture wrong");
    AST_CLR_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == OSCC_MODE_CLRI && ev.in1_valid && run)
        |=> up_counter == 16'h0000)
        else $error("counter not cleared on valid edge");
    AST_OPP_SILENT: assert property (@(posedge pclk) disable iff (!presetn)
        (cap_first && capture_compare_config_reg[OSCC_CC_FIRST_OPP_BIT]
         && !m1) |=> !first_match_irq)
        else $error("opposite edge raised irq");
    AST_TRIG_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        trig |=> up_counter == 16'h0000)
        else $error("trigger did not restart counter");
    AST_COUNT_INC: assert property (@(posedge pclk) disable iff (!presetn)
        (cnt_tick && !trig && !ev.in1_valid && run)
        |=> up_counter == $past(up_counter) + 16'h0001)
        else $error("counter did not increment");
    COV_ONESHOT: cover property (@(posedge pclk) trig ##[1:200] m1);
    COV_CAP_FIRST: cover property (@(posedge pclk) cap_first);
    COV_OVF: cover property (@(posedge pclk) ovf_evt);
endmodule : oscc_timer

// >>> test/oscc_pulse_src.sv
// Purpose: Far-side pulse source driving the two capture pins
// Assumes: Changes only just after rising pclk edges
// Notes:   Pins idle low at start; gaps are whole pclk cycles
`timescale 1ns/1ps
module oscc_pulse_src
(
    input  wire logic pclk, // Bench clock
    output logic      pin1, // Capture pin one
    output logic      pin2  // Capture pin two
);
    // Known level from time zero, no unknown reaches the synchroniser
    initial
    begin
        pin1 = 1'b0;
        pin2 = 1'b0;
    end
    // Invert one pin, then leave it quiet for gap cycles
    task automatic toggle(input int which, input int gap);
        @(posedge pclk);
        if (which == 1)
            pin1 <= ~pin1;
        else
            pin2 <= ~pin2;
        repeat (gap) @(posedge pclk);
    endtask : toggle
    // Low, rise, high for h, fall, low for l, final rise
    task automatic pulse(input int h, input int l);
        @(posedge pclk);
        pin1 <= 1'b0;
        repeat (10) @(posedge pclk);
        pin1 <= 1'b1;
        repeat (h) @(posedge pclk);
        pin1 <= 1'b0;
        repeat (l) @(posedge pclk);
        pin1 <= 1'b1;
        repeat (10) @(posedge pclk);
    endtask : pulse
endmodule : oscc_pulse_src

// >>> test/testbench.sv
// Purpose: Self-checking bench for the one-shot and capture timer
// Assumes: Zero-wait APB slave, prescaler left at one tick per pclk
// Notes:   Capture windows allow for the pin synchroniser delay
`timescale 1ns/1ps
module testbench;
    import oscc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, p1, p2, tout, irq1, irq2, last;
    logic [15:0] a, b;
    logic [1:0]  md [2];
    int          miscompares, cmp_count, n1, n2, i1, i2, c0;
    time         t_rise, t_fall, t0;

    oscc_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_input_first(p1), .capture_input_second(p2),
        .timer_output_pin(tout), .first_match_irq(irq1),
        .second_match_irq(irq2));
    oscc_pulse_src src_u (.pclk(pclk), .pin1(p1), .pin2(p2));

    // 20 MHz clock
    always #25 pclk = ~pclk;

    // Output pin edge times and irq pulse counts
    always @(posedge pclk)
    begin
        if (irq1 === 1'b1) n1++;
        if (irq2 === 1'b1) n2++;
        if (tout !== last && tout === 1'b1) t_rise = $time;
        if (tout !== last && tout === 1'b0) t_fall = $time;
        last = tout;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Window compare, unknown value never lands inside
    task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
        cmp_count++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h",
                     $time, got, lo, hi);
        end
    endtask : chk_rng

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) miscompares++;
    endtask : apb

    task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    task automatic results();
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    // Hang guard, well beyond the overflow wait
    initial
    begin
        repeat (90000) @(posedge pclk);
        miscompares++;
        results();
    end

    // Main sequence
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, last} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {miscompares, cmp_count, n1, n2} = '0;
        {t_rise, t_fall} = '0;
        md = '{OSCC_MODE_FREE, OSCC_MODE_CLRI};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Reset state, stopped counter holds zero
        rdchk(OSCC_OFF_MODE, 32'h0);
        rdchk(OSCC_OFF_COUNT, 32'h0);
        apb(1'b1, 8'h24, 32'h0000ffff);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h24, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, OSCC_OFF_CCF, 32'h0000a5c3);
        rdchk(OSCC_OFF_CCF, 32'h0000a5c3);
        apb(1'b1, OSCC_OFF_CCF, 32'h0);
        // Stopped timer ignores a pin edge
        apb(1'b1, OSCC_OFF_CCCFG, 32'h5);
        apb(1'b1, OSCC_OFF_EDGE, 32'hf);
        src_u.toggle(1, 10);
        rdchk(OSCC_OFF_CCS, 32'h0);
        chk(n2, 0);
        // Free running, both-edge select; pin two rise captures first, pin one fall captures second
        apb(1'b1, OSCC_OFF_MODE, 32'h4);
        apb(1'b0, OSCC_OFF_COUNT, 32'h0);
        c0 = int'(rd[15:0]);
        apb(1'b0, OSCC_OFF_COUNT, 32'h0);
        chk_rng(rd, c0 + 1, c0 + 8);
        src_u.toggle(2, 10);
        apb(1'b0, OSCC_OFF_CCF, 32'h0);
        a = rd[15:0];
        chk_rng(rd, c0 + 1, c0 + 40);
        chk(n1, 1);
        src_u.toggle(1, 10);
        apb(1'b0, OSCC_OFF_CCS, 32'h0);
        chk_rng(rd, int'(a) + 1, int'(a) + 40);
        chk(n2, 1);
        // Single-pin width, free mode then clear-on-edge mode
        foreach (md[i])
        begin
            apb(1'b1, OSCC_OFF_MODE, 32'h0);
            apb(1'b1, OSCC_OFF_CCCFG, 32'h7);
            apb(1'b1, OSCC_OFF_EDGE, {30'h0, OSCC_EDGE_RISE});
            apb(1'b1, OSCC_OFF_MODE, {28'h0, md[i], 2'h0});
            i1 = n1;
            src_u.pulse(40, 60);
            apb(1'b0, OSCC_OFF_CCF, 32'h0);
            a = rd[15:0];
            apb(1'b0, OSCC_OFF_CCS, 32'h0);
            b = rd[15:0];
            chk_rng({16'h0, b - a}, 59, 61);
            chk(n1, i1);
        end
        chk_rng({16'h0, a}, 39, 41);
        // One-shot from the soft trigger
        apb(1'b1, OSCC_OFF_MODE, 32'h0);
        apb(1'b1, OSCC_OFF_CCCFG, 32'h0);
        apb(1'b1, OSCC_OFF_CCF, 32'h0000000a);
        apb(1'b1, OSCC_OFF_CCS, 32'h0000001e);
        apb(1'b1, OSCC_OFF_MODE, 32'h4);
        i1 = n1;
        i2 = n2;
        // Enable first, so the trigger write finds one-shot already on
        apb(1'b1, OSCC_OFF_OUTCTL, 32'h33);
        apb(1'b1, OSCC_OFF_OUTCTL, 32'h73);
        t0 = $time;
        repeat (15) @(posedge pclk);
        rdchk(OSCC_OFF_STAT, 32'h3);
        repeat (45) @(posedge pclk);
        chk_rng(32'((t_rise - t0) / 50), 11, 14);
        chk(32'((t_fall - t_rise) / 50), 32'h14);
        chk(n1 - i1, 1);
        chk(n2 - i2, 1);
        // Clear-on-edge period across one 16-bit wrap, then clear the flag
        apb(1'b1, OSCC_OFF_OUTCTL, 32'h0);
        apb(1'b1, OSCC_OFF_MODE, 32'h0);
        apb(1'b1, OSCC_OFF_CCCFG, 32'h7);
        apb(1'b1, OSCC_OFF_MODE, 32'h8);
        src_u.pulse(100, 65500);
        apb(1'b0, OSCC_OFF_MODE, 32'h0);
        chk({31'h0, rd[OSCC_MODE_OVF_BIT]}, 32'h1);
        c0 = int'(rd[OSCC_MODE_OVF_BIT]);
        apb(1'b0, OSCC_OFF_CCS, 32'h0);
        chk_rng(32'(c0) * 32'h0001_0000 + {16'h0, rd[15:0]},
                65599, 65601);
        apb(1'b1, OSCC_OFF_MODE, 32'h8);
        rdchk(OSCC_OFF_MODE, 32'h8);
        results();
    end
endmodule : testbench
